// >>> core/stp_defs.svh
// timing, channel and table constants of the safe input test pulse generator
`ifndef STP_DEFS_SVH
`define STP_DEFS_SVH

`define STP_CHANNELS      8
`define STP_CNT_W         20
`define STP_CLK_MHZ       125
`define STP_PULSE_LOW_US  350
`define STP_GAP_UNIT_US   50
// gap before each channel's pulse in gap units, channel 7 in the top nibble
`define STP_GAP_TABLE     32'h96978564
`define STP_GAP_SUM_UNITS 54
`define STP_RATE_PER_S    180
`define STP_PULSE_CYCLES  (`STP_PULSE_LOW_US * `STP_CLK_MHZ)
`define STP_GAP_CYCLES    (`STP_GAP_UNIT_US * `STP_CLK_MHZ)
`define STP_TEST_CYCLES   (`STP_GAP_SUM_UNITS * `STP_GAP_CYCLES + `STP_CHANNELS * `STP_PULSE_CYCLES)

`endif

// >>> core/stp_pkg.sv
// types of the safe input test pulse generator
`include "stp_defs.svh"

package stp_pkg;

	// sequencer states
	typedef enum logic [1:0] {
		STP_START = 2'b00,
		STP_GAP   = 2'b01,
		STP_PULSE = 2'b10
	} stp_state_e;

	// complete state of the generator
	typedef struct packed {
		stp_state_e                   state;      // sequencer state
		logic [`STP_CNT_W-1:0]        cnt;        // cycles left in phase
		logic [2:0]                   ch;         // channel of current slot
		logic [3:0]                   last_gap;   // gap units of previous gap
		logic [`STP_CHANNELS-1:0]     pulse_out;  // pulse output levels
		logic [`STP_CHANNELS-1:0]     in_state;   // raw input states
		logic                         led_ctrl;   // control supply indicator
		logic                         led_periph; // peripheral supply indicator
		logic [`STP_CHANNELS-1:0]     diag_err;   // sticky wiring errors
	} stp_state_s;

endpackage : stp_pkg

// >>> core/stp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps

module stp_sync #(
	parameter int W = 10  // number of bits
) (
	input  wire logic         clock,  // system clock
	input  wire logic         rst_b,  // async reset, active low
	input  wire logic         ce,     // clock enable
	input  wire logic [W-1:0] d,      // asynchronous input
	output logic      [W-1:0] q       // synchronised output
);

	// both stages; first stage is read by the second only
	typedef struct packed {
		logic [W-1:0] s1;  // metastability catcher
		logic [W-1:0] s2;  // stable copy
	} stp_sync_s;

	stp_sync_s st;       // registered state
	stp_sync_s next_st;  // next state

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_st    = st;
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end

	// register, frozen while ce is low
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign q = st.s2;

endmodule : stp_sync

// >>> core/stp_pulse_gen.sv
// safe input test pulse generator with supply indicators and wiring diagnostics
// Operation
// R1: pulse drives output high, low 350 us, high
// R2: about 180 pulses per second per channel
// R3: each of eight outputs pulsed on its own
// R4: pulses only while channel sensor test enabled
// R5: full test cycle of eight channels 5.5 ms
// R6: spacing between channel pulses varies
// R7: green indicators show control and peripheral supply
// R8: only pulse outputs need peripheral supply
// R9: controller interprets contacts; device reports raw inputs
// R10: self-testing switch output pairs keep test off
// R11: input low while pulse low, else error
`timescale 1ns/100ps
`include "stp_defs.svh"

module stp_pulse_gen #(
	parameter int PULSE_CYCLES = `STP_PULSE_CYCLES,  // low phase length in cycles
	parameter int GAP_CYCLES   = `STP_GAP_CYCLES     // one gap unit in cycles
) (
	input  wire logic                     clock,              // 125 MHz clock
	input  wire logic                     rst_b,              // async reset, active low
	input  wire logic                     ce,                 // clock enable
	input  wire logic [`STP_CHANNELS-1:0] sensor_test_en,     // per channel pulse enable
	input  wire logic [`STP_CHANNELS-1:0] diag_clear,         // per channel error clear
	input  wire logic [`STP_CHANNELS-1:0] in_raw,             // safe input pins
	input  wire logic                     control_ok,         // control supply present pin
	input  wire logic                     periph_ok,          // peripheral supply present pin
	output logic      [`STP_CHANNELS-1:0] pulse_out,          // pulse output pins
	output logic      [`STP_CHANNELS-1:0] in_state,           // raw input states
	output logic                          led_control_supply, // control supply led, green
	output logic                          led_periph_supply,  // peripheral supply led, green
	output logic      [`STP_CHANNELS-1:0] diag_err            // sticky wiring errors
);

	localparam logic [31:0] GAP_TABLE = `STP_GAP_TABLE;  // gap units per channel

	stp_pkg::stp_state_s      st;       // registered state
	stp_pkg::stp_state_s      next_st;  // next state
	logic [`STP_CHANNELS+1:0] pins_s;   // synchronised pin inputs
	logic [`STP_CHANNELS-1:0] in_s;     // synchronised safe inputs
	logic                     ctrl_s;   // synchronised control supply
	logic                     per_s;    // synchronised peripheral supply
	logic [`STP_CHANNELS-1:0] diag_hit; // per channel mismatch this cycle
	logic [3:0]               gap_u;    // gap units for next channel

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: all pins come from outside the clock domain
	stp_sync #(
		.W (`STP_CHANNELS + 2)
	) u_sync (
		.clock (clock),
		.rst_b (rst_b),
		.ce    (ce),
		.d     ({periph_ok, control_ok, in_raw}),
		.q     (pins_s)
	);

	assign in_s   = pins_s[`STP_CHANNELS-1:0];
	assign ctrl_s = pins_s[`STP_CHANNELS];
	assign per_s  = pins_s[`STP_CHANNELS+1];

	////////////////////////////////////////////////////////////////////////////////
	// per channel mismatch check on the last cycle of its low phase
	genvar gi;
	generate
		for (gi = 0; gi < `STP_CHANNELS; gi++) begin : g_diag
			// R11: input must follow low pulse
			assign diag_hit[gi] = (st.state == stp_pkg::STP_PULSE) && (st.ch == 3'(gi))
				&& (st.cnt == `STP_CNT_W'(1)) && !st.pulse_out[gi] && st.led_periph
				&& in_s[gi];
		end
	endgenerate

	// gap of the slot that follows the current pulse
	assign gap_u = GAP_TABLE[{3'(st.ch + 3'h1), 2'b00} +: 4];

	////////////////////////////////////////////////////////////////////////////////
	// sequencer: gap then low phase for each channel in turn
	always_comb begin
		next_st = st;
		case (st.state)
			// first slot starts after reset with channel 0's gap
			stp_pkg::STP_START: begin
				next_st.state    = stp_pkg::STP_GAP;
				next_st.ch       = 3'h0;
				next_st.cnt      = `STP_CNT_W'(GAP_TABLE[3:0] * GAP_CYCLES);
				next_st.last_gap = GAP_TABLE[3:0];
			end
			// waiting between pulses
			stp_pkg::STP_GAP: begin
				if (st.cnt == `STP_CNT_W'(1)) begin
					// R1: low phase length
					next_st.state = stp_pkg::STP_PULSE;
					next_st.cnt   = `STP_CNT_W'(PULSE_CYCLES);
				end else begin
					next_st.cnt = st.cnt - `STP_CNT_W'(1);
				end
			end
			// channel held low; slot time kept even when disabled so cycle stays fixed
			stp_pkg::STP_PULSE: begin
				if (st.cnt == `STP_CNT_W'(1)) begin
					// R5: eight slots fill cycle
					// R2: cycle sets pulse rate
					// R6: table gaps differ slot to slot
					next_st.state    = stp_pkg::STP_GAP;
					next_st.ch       = st.ch + 3'h1;
					next_st.cnt      = `STP_CNT_W'(gap_u * GAP_CYCLES);
					next_st.last_gap = gap_u;
				end else begin
					next_st.cnt = st.cnt - `STP_CNT_W'(1);
				end
			end
			default: begin
				next_st.state = stp_pkg::STP_START;
			end
		endcase

		// R3: one channel low at a time
		// R4: only enabled channels go low
		// R8: outputs dark without peripheral supply
		next_st.pulse_out = {`STP_CHANNELS{per_s}} & ~(sensor_test_en
			& ((next_st.state == stp_pkg::STP_PULSE)
			? (`STP_CHANNELS'(1) << next_st.ch) : '0));

		// R9: raw inputs reported unchanged
		// R8: inputs kept without peripheral supply
		next_st.in_state = in_s;

		// R7: supply indicators
		next_st.led_ctrl   = ctrl_s;
		next_st.led_periph = per_s;

		// R11: sticky error, set wins over clear
		next_st.diag_err = (st.diag_err & ~diag_clear) | diag_hit;
	end

	// state register, frozen while ce is low
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st           <= '0;
			st.state     <= stp_pkg::STP_START;
			st.pulse_out <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign pulse_out          = st.pulse_out;
	assign in_state           = st.in_state;
	assign led_control_supply = st.led_ctrl;
	assign led_periph_supply  = st.led_periph;
	assign diag_err           = st.diag_err;

	////////////////////////////////////////////////////////////////////////////////
	// assertion helpers: low phase length and channel 0 period
	int   low_cnt;  // cycles spent in the low phase
	int   per_cnt;  // cycles since channel 0 pulse started
	logic seen0;    // one channel 0 start seen
	logic start0;   // channel 0 low phase begins
	stp_pkg::stp_state_e prev_state;  // state one enabled cycle ago
	logic [1:0] since_rst;            // enabled edges since reset, stops at 3

	// rate check: cycle length times 350 us times 180 per second, times 100, lands near
	// PULSE_CYCLES times 1e8; a band of 2 percent either way covers the 5.5 ms cycle
	localparam longint RATE_MUL = 64'(`STP_PULSE_LOW_US * `STP_RATE_PER_S * 100); // scale
	localparam longint RATE_LO  = 64'h5d75c80;  // 98 percent of 1e8
	localparam longint RATE_HI  = 64'h6146580;  // 102 percent of 1e8

	assign start0 = (st.state == stp_pkg::STP_PULSE) && (st.ch == 3'h0)
		&& (prev_state != stp_pkg::STP_PULSE);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			low_cnt    <= 0;
			per_cnt    <= 0;
			seen0      <= 1'b0;
			prev_state <= stp_pkg::STP_START;
			since_rst  <= 2'h0;
		end else if (ce) begin
			low_cnt    <= (st.state == stp_pkg::STP_PULSE) ? low_cnt + 1 : 0;
			per_cnt    <= start0 ? 1 : per_cnt + 1;
			seen0      <= seen0 | start0;
			prev_state <= st.state;
			since_rst  <= (since_rst == 2'h3) ? 2'h3 : since_rst + 2'h1;
		end
	end

	default clocking cb @(posedge clock iff ce);
	endclocking
	default disable iff (!rst_b);

	a_low_phase_len: assert property ( // R1
		(st.state != stp_pkg::STP_PULSE && low_cnt != 0) |-> low_cnt == PULSE_CYCLES)
		else $error("low phase length wrong");
	a_test_cycle_len: assert property ( // R5
		(start0 && seen0)
		|-> per_cnt == `STP_GAP_SUM_UNITS * GAP_CYCLES + `STP_CHANNELS * PULSE_CYCLES)
		else $error("test cycle length wrong");
	// timing parameters may be shortened, so the rate is judged in low phase units
	a_channel_rate: assert property ( // R2
		(start0 && seen0)
		|-> (longint'(per_cnt) * RATE_MUL > longint'(PULSE_CYCLES) * RATE_LO)
		&& (longint'(per_cnt) * RATE_MUL < longint'(PULSE_CYCLES) * RATE_HI))
		else $error("pulse rate off");
	a_one_low: assert property ( // R3
		st.led_periph |-> $countones(~st.pulse_out) <= 1)
		else $error("two channels low");
	a_disabled_high: assert property ( // R4
		((~st.pulse_out) & ~$past(sensor_test_en) & {`STP_CHANNELS{st.led_periph}}) == '0)
		else $error("disabled channel pulsed");
	a_gap_varies: assert property ( // R6
		(st.state == stp_pkg::STP_PULSE && st.cnt == `STP_CNT_W'(1))
		|=> st.last_gap != $past(st.last_gap))
		else $error("gap did not vary");
	// the three flop path holds reset zeros for three edges, so wait until it is full
	a_led_follows: assert property ( // R7
		since_rst == 2'h3 |-> led_control_supply == $past(control_ok, 3)
		&& led_periph_supply == $past(periph_ok, 3))
		else $error("indicator lags supply");
	a_inputs_kept: assert property ( // R8
		since_rst == 2'h3 |-> in_state == $past(in_raw, 3)
		&& (led_periph_supply || pulse_out == '0))
		else $error("input or output supply dependence wrong");
	a_diag_set: assert property ( // R11
		diag_hit != '0 |=> (diag_err & $past(diag_hit)) == $past(diag_hit))
		else $error("wiring error not flagged");

	c_pulse_seen: cover property (start0 && seen0);
	c_diag_hit:   cover property (diag_hit != '0);
	c_periph_off: cover property (!led_periph_supply && led_control_supply);

endmodule : stp_pulse_gen

// >>> sim/stp_contact_model.sv
// contact model: switching contacts wired between pulse outputs and safe inputs
`timescale 1ns/100ps
`include "stp_defs.svh"

module stp_contact_model (
	input  wire logic [`STP_CHANNELS-1:0] pulse_out, // pulse output pins
	input  wire logic [`STP_CHANNELS-1:0] closed,    // contact closed per channel
	input  wire logic [`STP_CHANNELS-1:0] stuck_hi,  // short to 24 V per channel
	output logic      [`STP_CHANNELS-1:0] in_raw     // safe input pins
);
	////////////////////////////////////////////////////////////////////////////////
	// raw contact level
	// an open contact reads low through the input pull-down, so no stale level
	// survives; a short to 24 V wins, which hides the test pulse on purpose
	assign in_raw = (pulse_out & closed) | stuck_hi;
endmodule : stp_contact_model

// >>> sim/tb_top.sv
// self-checking bench of the safe input test pulse generator
`timescale 1ns/100ps
`include "stp_defs.svh"

module tb_top;
	localparam int PC  = 21; // shortened low phase, kept 7 to 1 against the gap unit
	localparam int GC  = 3;  // shortened gap unit
	localparam int CYC = `STP_GAP_SUM_UNITS * GC + `STP_CHANNELS * PC; // test cycle
	logic        clock          = 1'b0;  // system clock
	logic        rst_b          = 1'b0;  // reset, active low
	logic        ce             = 1'b1;  // clock enable
	logic [7:0]  sensor_test_en = 8'h00; // pulse enables
	logic [7:0]  diag_clear     = 8'h00; // error clears
	logic [7:0]  closed         = 8'hff; // contact states
	logic [7:0]  stuck_hi       = 8'h00; // injected wiring faults
	logic        control_ok     = 1'b1;  // control supply pin
	logic        periph_ok      = 1'b1;  // peripheral supply pin
	logic [7:0]  in_raw;                 // safe input pins
	logic [7:0]  pulse_out;              // pulse output pins
	logic [7:0]  in_state;               // reported input states
	logic [7:0]  diag_err;               // wiring errors
	logic        led_control_supply;     // control supply led
	logic        led_periph_supply;      // peripheral supply led
	logic [31:0] gt = `STP_GAP_TABLE;    // gap units per channel
	int          fail_count = 0;         // mismatches
	int          n_checks   = 0;         // comparisons
	int          f1[8];                  // first fall per channel
	int          f2[8];                  // second fall per channel
	int          run[8];                 // current low run length

	always #4 clock = ~clock;

	stp_pulse_gen #(.PULSE_CYCLES(PC), .GAP_CYCLES(GC)) stp_pulse_gen_i (
		.clock(clock), .rst_b(rst_b), .ce(ce), .sensor_test_en(sensor_test_en),
		.diag_clear(diag_clear), .in_raw(in_raw), .control_ok(control_ok),
		.periph_ok(periph_ok), .pulse_out(pulse_out), .in_state(in_state),
		.led_control_supply(led_control_supply), .led_periph_supply(led_periph_supply),
		.diag_err(diag_err));

	stp_contact_model stp_contact_model_i (
		.pulse_out(pulse_out), .closed(closed), .stuck_hi(stuck_hi), .in_raw(in_raw));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk

	task automatic give_verdict;
		if (fail_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict

	// inputs always change one fixed delay after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step

	task automatic do_reset(input logic [7:0] en);
		rst_b = 1'b0;
		sensor_test_en = en;
		step(3);
		chk("reset outputs", {pulse_out, diag_err, led_control_supply, led_periph_supply}, 0);
		rst_b = 1'b1;
	endtask : do_reset

	// records falls and low runs; a run is judged only once its fall was seen
	task automatic watch(input int n);
		logic [7:0] prev;
		int         lows;
		prev = pulse_out;
		for (int i = 0; i < 8; i++) begin
			f1[i] = -1;
			f2[i] = -1;
			run[i] = 0;
		end
		for (int c = 0; c < n; c++) begin
			step(1);
			lows = 0;
			for (int i = 0; i < 8; i++) begin
				if (pulse_out[i] === 1'b0 && led_periph_supply === 1'b1) begin
					lows++;
					if (prev[i] === 1'b1 && f1[i] < 0) f1[i] = c;
					else if (prev[i] === 1'b1 && f2[i] < 0) f2[i] = c;
					if (f1[i] >= 0) run[i]++;
				end else if (run[i] > 0) begin
					chk("low phase length", run[i], PC);
					run[i] = 0;
				end
			end
			if (lows > 1) chk("overlapping pulses", lows, 1);
			prev = pulse_out;
		end
	endtask : watch

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_sequence;
		do_reset(8'hff);
		watch(2 * CYC + 20);
		chk("first pulse start", f1[0], gt[3:0] * GC);
		for (int i = 1; i < 8; i++) chk("spacing", f1[i] - f1[i-1], PC + gt[4*i +: 4] * GC);
		for (int i = 0; i < 8; i++) chk("test cycle", f2[i] - f1[i], CYC);
	endtask : t_sequence

	// disabled channels stay high, as pairs with self-testing outputs need
	task automatic t_disabled;
		do_reset(8'h5a);
		watch(CYC + 40);
		for (int i = 0; i < 8; i++) chk("pulsed", f1[i] >= 0, sensor_test_en[i]);
		chk("idle level", pulse_out, 8'hff);
	endtask : t_disabled

	task automatic t_supply;
		do_reset(8'h00);
		step(6);
		chk("indicators", {led_control_supply, led_periph_supply}, 2'b11);
		chk("raw inputs", in_state, 8'hff);
		periph_ok = 1'b0;
		closed = 8'h00;
		stuck_hi = 8'hc3;
		step(4);
		chk("indicators", {led_control_supply, led_periph_supply}, 2'b10);
		chk("outputs unpowered", pulse_out, 8'h00);
		chk("inputs kept", in_state, 8'hc3);
		control_ok = 1'b0;
		step(4);
		chk("control led", led_control_supply, 1'b0);
		// clock enable low must freeze even the synchronisers
		ce = 1'b0;
		control_ok = 1'b1;
		step(4);
		chk("frozen led", led_control_supply, 1'b0);
		ce = 1'b1;
		step(3);
		chk("control led back", led_control_supply, 1'b1);
		periph_ok = 1'b1;
		closed = 8'hff;
		stuck_hi = 8'h00;
	endtask : t_supply

	// a short to 24 V on one input must be caught during its pulse
	task automatic t_diag;
		int k;
		stuck_hi = 8'h04;
		do_reset(8'hff);
		for (k = 0; k < 2 * CYC && diag_err === 8'h00; k++) step(1);
		if (k == 2 * CYC) begin
			chk("diag timeout", 0, 1);
		end else begin
			step(1);
			chk("diag error", diag_err, 8'h04);
			stuck_hi = 8'h00;
			diag_clear = 8'h04;
			step(2);
			diag_clear = 8'h00;
			step(CYC + 10);
			chk("diag cleared", diag_err, 8'h00);
		end
	endtask : t_diag

	initial begin
		t_sequence();
		t_disabled();
		t_supply();
		t_diag();
		give_verdict();
	end
endmodule : tb_top
